// ===== core/rxpft_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the receive pause termination block.
// Assumes byte addresses on an 8-bit register port, 32-bit words.
`ifndef RXPFT_REGS_VH
`define RXPFT_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RXPFT_CTRL          8'h00
`define RXPFT_CHECK         8'h04
`define RXPFT_UDA_LO        8'h08
`define RXPFT_UDA_HI        8'h0c
`define RXPFT_MDA_LO        8'h10
`define RXPFT_MDA_HI        8'h14
`define RXPFT_SA_LO         8'h18
`define RXPFT_SA_HI         8'h1c
`define RXPFT_ETYPE_CTRL    8'h20
`define RXPFT_ETYPE_PAUSE   8'h24
`define RXPFT_OPC_GCP       8'h28
`define RXPFT_OPC_PCP       8'h2c
`define RXPFT_OPC_PAUSE     8'h30
`define RXPFT_STATUS        8'h34

// ****************************************
// Field positions
// ****************************************
`define RXPFT_CTRL_FWD      0
`define RXPFT_CTRL_ACK      1
`define RXPFT_CTRL_EN_LO    16
`define RXPFT_CLS_GCP       0
`define RXPFT_CLS_PCP       8
`define RXPFT_CLS_GPP       16
`define RXPFT_CLS_PPP       24
`define RXPFT_CHK_UCAST     0
`define RXPFT_CHK_MCAST     1
`define RXPFT_CHK_SA        2
`define RXPFT_CHK_ETYPE     3
`define RXPFT_CHK_OPCODE    4
`define RXPFT_CHK_ENABLE    5

// ****************************************
// Reset values and fixed constants
// ****************************************
`define RXPFT_RST_CTRL      32'h0000_0000
`define RXPFT_RST_CHECK     32'h0000_0000
`define RXPFT_RST_MDA       48'h0180c2000001
`define RXPFT_FIXED_MDA     48'h0180c2000001
`define RXPFT_RST_ETYPE     32'h8808_8808
`define RXPFT_RST_OPC_GCP   32'hffff_0000
`define RXPFT_RST_OPC_PCP   32'hffff_0000
`define RXPFT_RST_OPC_PAUSE 32'h0101_0001

// ****************************************
// Timing counts
// ****************************************
`define RXPFT_QUANTA_CYCLES 8'h08
`define RXPFT_ACK_HOLD_LAST 5'h1f
`define RXPFT_HDR_BYTES     6'h22

`endif

// ===== core/rxpft_top.v
// Receive pause frame termination: classifies frames and runs nine
// pause handshakes (one global, eight priority) with user logic.
// Assumes a byte stream whose first byte carries rx_sof, and a register
// master that follows the single-cycle strobe protocol.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rxpft_regs.vh"

module rxpft_top
(
    input  wire        clock,      // 10 MHz clock
    input  wire        rst,        // Synchronous reset, high
    input  wire [7:0]  addr,       // Register byte address
    input  wire [31:0] wr_data,    // Register write data
    input  wire        wr_en,      // Write strobe
    input  wire        rd_en,      // Read strobe
    output reg  [31:0] rd_data,    // Read data, cycle after rd_en
    input  wire        rx_valid,   // Frame byte valid
    input  wire        rx_sof,     // First byte of frame
    input  wire        rx_eof,     // Last byte of frame
    input  wire [7:0]  rx_byte,    // Frame byte
    input  wire [8:0]  pause_ack,  // User acknowledge per class
    output wire [8:0]  pause_req,  // Pause request per class
    output reg         ctrl_fwd,   // Control frame forwarded, pulse
    output reg         ctrl_drop   // Control frame dropped, pulse
);

    // ****************************************
    // Registers
    // ****************************************
    reg  [31:0] ctrl;
    reg  [31:0] check;
    reg  [47:0] uda;
    reg  [47:0] mda;
    reg  [47:0] sa_cfg;
    reg  [31:0] etype_ctrl;
    reg  [31:0] etype_pause;
    reg  [31:0] opc_gcp;
    reg  [31:0] opc_pcp;
    reg  [31:0] opc_pause;
    reg  [31:0] next_rd;

    always @(posedge clock)
    begin
        if (rst)
        begin
            ctrl        <= `RXPFT_RST_CTRL;
            check       <= `RXPFT_RST_CHECK;
            uda         <= 48'h0;
            mda         <= `RXPFT_RST_MDA;
            sa_cfg      <= 48'h0;
            etype_ctrl  <= `RXPFT_RST_ETYPE;
            etype_pause <= `RXPFT_RST_ETYPE;
            opc_gcp     <= `RXPFT_RST_OPC_GCP;
            opc_pcp     <= `RXPFT_RST_OPC_PCP;
            opc_pause   <= `RXPFT_RST_OPC_PAUSE;
        end
        else if (wr_en)
        begin
            // Reserved bits are masked so that they read back 0
            case (addr)
                `RXPFT_CTRL:        ctrl <= wr_data & 32'h01ff_0003;
                `RXPFT_CHECK:       check <= wr_data & 32'h3f3f_3f3f;
                `RXPFT_UDA_LO:      uda[31:0] <= wr_data;
                `RXPFT_UDA_HI:      uda[47:32] <= wr_data[15:0];
                `RXPFT_MDA_LO:      mda[31:0] <= wr_data;
                `RXPFT_MDA_HI:      mda[47:32] <= wr_data[15:0];
                `RXPFT_SA_LO:       sa_cfg[31:0] <= wr_data;
                `RXPFT_SA_HI:       sa_cfg[47:32] <= wr_data[15:0];
                `RXPFT_ETYPE_CTRL:  etype_ctrl <= wr_data;
                `RXPFT_ETYPE_PAUSE: etype_pause <= wr_data;
                `RXPFT_OPC_GCP:     opc_gcp <= wr_data;
                `RXPFT_OPC_PCP:     opc_pcp <= wr_data;
                `RXPFT_OPC_PAUSE:   opc_pause <= wr_data;
                default:            ;
            endcase
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Unmapped and reserved offsets fall to the default and read 0
    always @*
    begin
        case (addr)
            `RXPFT_CTRL:        next_rd = ctrl;
            `RXPFT_CHECK:       next_rd = check;
            `RXPFT_UDA_LO:      next_rd = uda[31:0];
            `RXPFT_UDA_HI:      next_rd = {16'h0, uda[47:32]};
            `RXPFT_MDA_LO:      next_rd = mda[31:0];
            `RXPFT_MDA_HI:      next_rd = {16'h0, mda[47:32]};
            `RXPFT_SA_LO:       next_rd = sa_cfg[31:0];
            `RXPFT_SA_HI:       next_rd = {16'h0, sa_cfg[47:32]};
            `RXPFT_ETYPE_CTRL:  next_rd = etype_ctrl;
            `RXPFT_ETYPE_PAUSE: next_rd = etype_pause;
            `RXPFT_OPC_GCP:     next_rd = opc_gcp;
            `RXPFT_OPC_PCP:     next_rd = opc_pcp;
            `RXPFT_OPC_PAUSE:   next_rd = opc_pause;
            `RXPFT_STATUS:      next_rd = {23'h0, pause_req};
            default:            next_rd = 32'h0;
        endcase
    end

    // Data shows only in the cycle after the strobe
    always @(posedge clock)
    begin
        if (rst)
            rd_data <= 32'h0;
        else if (rd_en)
            rd_data <= next_rd;
        else
            rd_data <= 32'h0;
    end

    // ****************************************
    // Control fields
    // ****************************************
    wire       fwd_ctrl  = ctrl[`RXPFT_CTRL_FWD];
    wire       check_ack = ctrl[`RXPFT_CTRL_ACK];
    wire [8:0] pause_en  = ctrl[`RXPFT_CTRL_EN_LO+8:`RXPFT_CTRL_EN_LO];

    // ****************************************
    // Header capture
    // ****************************************
    // Short frames leave older bytes in place; only fields that the
    // frame actually carried are meaningful.
    reg  [7:0] hdr [0:33];
    reg  [5:0] idx;
    reg        eval;

    always @(posedge clock)
    begin
        if (rst)
        begin
            idx  <= 6'h0;
            eval <= 1'b0;
        end
        else
        begin
            // Judged a cycle after the end byte, once that byte is stored
            eval <= rx_valid & rx_eof;
            if (rx_valid & rx_sof)
            begin
                hdr[0] <= rx_byte;
                idx    <= 6'h01;
            end
            else if (rx_valid && idx < `RXPFT_HDR_BYTES)
            begin
                hdr[idx] <= rx_byte;
                idx      <= idx + 6'h01;
            end
        end
    end

    wire [47:0] da    = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]};
    wire [47:0] sa    = {hdr[6], hdr[7], hdr[8], hdr[9], hdr[10], hdr[11]};
    wire [15:0] etype = {hdr[12], hdr[13]};
    wire [15:0] opc   = {hdr[14], hdr[15]};
    // Enable vector is the low byte of the global quanta field
    wire [7:0]  pvec  = hdr[17];

    // ****************************************
    // Classification
    // ****************************************
    wire [5:0] c_gcp = check[`RXPFT_CLS_GCP+5:`RXPFT_CLS_GCP];
    wire [5:0] c_pcp = check[`RXPFT_CLS_PCP+5:`RXPFT_CLS_PCP];
    wire [5:0] c_gpp = check[`RXPFT_CLS_GPP+5:`RXPFT_CLS_GPP];
    wire [5:0] c_ppp = check[`RXPFT_CLS_PPP+5:`RXPFT_CLS_PPP];

    wire da_gcp = (!c_gcp[`RXPFT_CHK_MCAST] && !c_gcp[`RXPFT_CHK_UCAST])
                || (da == uda && c_gcp[`RXPFT_CHK_UCAST])
                || (da == `RXPFT_FIXED_MDA && c_gcp[`RXPFT_CHK_MCAST]);
    wire sa_gcp = !c_gcp[`RXPFT_CHK_SA] || sa == sa_cfg;
    wire et_gcp = !c_gcp[`RXPFT_CHK_ETYPE] || etype == etype_ctrl[15:0];
    wire op_gcp = !c_gcp[`RXPFT_CHK_OPCODE]
                || (opc >= opc_gcp[15:0] && opc <= opc_gcp[31:16]);
    wire gcp    = da_gcp && sa_gcp && et_gcp && op_gcp && c_gcp[`RXPFT_CHK_ENABLE];

    wire da_pcp = (!c_pcp[`RXPFT_CHK_MCAST] && !c_pcp[`RXPFT_CHK_UCAST])
                || (da == uda && c_pcp[`RXPFT_CHK_UCAST])
                || (da == mda && c_pcp[`RXPFT_CHK_MCAST]);
    wire sa_pcp = !c_pcp[`RXPFT_CHK_SA] || sa == sa_cfg;
    wire et_pcp = !c_pcp[`RXPFT_CHK_ETYPE] || etype == etype_ctrl[31:16];
    wire op_pcp = !c_pcp[`RXPFT_CHK_OPCODE]
                || (opc >= opc_pcp[15:0] && opc <= opc_pcp[31:16]);
    wire pcp    = da_pcp && sa_pcp && et_pcp && op_pcp && c_pcp[`RXPFT_CHK_ENABLE];

    // Pause tests below only count when this holds
    wire ctrl_frame = gcp || pcp;

    wire da_gpp = (!c_gpp[`RXPFT_CHK_MCAST] && !c_gpp[`RXPFT_CHK_UCAST])
                || (da == uda && c_gpp[`RXPFT_CHK_UCAST])
                || (da == `RXPFT_FIXED_MDA && c_gpp[`RXPFT_CHK_MCAST]);
    wire sa_gpp = !c_gpp[`RXPFT_CHK_SA] || sa == sa_cfg;
    wire et_gpp = !c_gpp[`RXPFT_CHK_ETYPE] || etype == etype_pause[15:0];
    wire op_gpp = !c_gpp[`RXPFT_CHK_OPCODE] || opc == opc_pause[15:0];
    wire gpp    = da_gpp && sa_gpp && et_gpp && op_gpp && c_gpp[`RXPFT_CHK_ENABLE];

    // Printed form joins the no-check term with AND; taken as OR here
    wire da_ppp = (!c_ppp[`RXPFT_CHK_MCAST] && !c_ppp[`RXPFT_CHK_UCAST])
                || (da == uda && c_ppp[`RXPFT_CHK_UCAST])
                || (da == mda && c_ppp[`RXPFT_CHK_MCAST]);
    wire sa_ppp = !c_ppp[`RXPFT_CHK_SA] || sa == sa_cfg;
    wire et_ppp = !c_ppp[`RXPFT_CHK_ETYPE] || etype == etype_pause[31:16];
    wire op_ppp = !c_ppp[`RXPFT_CHK_OPCODE] || opc == opc_pause[31:16];
    wire ppp    = da_ppp && sa_ppp && et_ppp && op_ppp && c_ppp[`RXPFT_CHK_ENABLE];

    // ****************************************
    // Frame decision
    // ****************************************
    wire       glob_hit = eval && ctrl_frame && gpp;
    wire       prio_hit = eval && ctrl_frame && !gpp && ppp;
    wire [8:0] hit      = {glob_hit, {8{prio_hit}} & pvec};

    // ****************************************
    // Control frame outputs
    // ****************************************
    always @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_fwd  <= 1'b0;
            ctrl_drop <= 1'b0;
        end
        else
        begin
            ctrl_fwd  <= eval && ctrl_frame && fwd_ctrl;
            ctrl_drop <= eval && ctrl_frame && !fwd_ctrl;
        end
    end

    // ****************************************
    // Quanta tick divider
    // ****************************************
    // Free-running: the first decrement after a load comes 1 to 8 cycles later
    reg [7:0] div;
    reg       tick;

    always @(posedge clock)
    begin
        if (rst)
        begin
            div  <= 8'h0;
            tick <= 1'b0;
        end
        else if (div == `RXPFT_QUANTA_CYCLES - 8'h01)
        begin
            div  <= 8'h0;
            tick <= 1'b1;
        end
        else
        begin
            div  <= div + 8'h01;
            tick <= 1'b0;
        end
    end

    // ****************************************
    // Per-class handshake
    // ****************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WACK = 2'h1;
    localparam [1:0] ST_CNT  = 2'h2;
    localparam [1:0] ST_REL  = 2'h3;

    genvar i;
    generate
        for (i = 0; i < 9; i = i + 1)
        begin : g_cls
            wire [15:0] quanta;
            // Split so that no branch indexes past the stored header
            if (i == 8)
            begin : g_glob
                assign quanta = {hdr[16], hdr[17]};
            end
            else
            begin : g_prio
                assign quanta = {hdr[18 + 2 * i], hdr[19 + 2 * i]};
            end
            wire        load   = hit[i] && pause_en[i];
            reg  [1:0]  st;
            reg         req;
            reg  [15:0] tmr;
            reg  [4:0]  hold;

            assign pause_req[i] = req;

            always @(posedge clock)
            begin
                if (rst)
                begin
                    st   <= ST_IDLE;
                    req  <= 1'b0;
                    tmr  <= 16'h0;
                    hold <= 5'h0;
                end
                else
                begin
                    case (st)
                        ST_IDLE:
                            if (load)
                            begin
                                req <= 1'b1;
                                tmr <= quanta;
                                st  <= check_ack ? ST_WACK : ST_CNT;
                            end
                        // Enable is only looked at for new frames, so a
                        // running sequence finishes even if disabled
                        ST_WACK:
                        begin
                            if (load)
                                tmr <= quanta;
                            if (pause_ack[i])
                                st <= ST_CNT;
                        end
                        // A reload wins over expiry in the same cycle
                        ST_CNT:
                            if (load)
                                tmr <= quanta;
                            else if (tmr == 16'h0)
                            begin
                                req  <= 1'b0;
                                hold <= 5'h0;
                                st   <= check_ack ? ST_REL : ST_IDLE;
                            end
                            else if (tick)
                                tmr <= tmr - 16'h0001;
                        // Reload here skips the ack wait; the user has answered
                        ST_REL:
                            if (load)
                            begin
                                req <= 1'b1;
                                tmr <= quanta;
                                st  <= ST_CNT;
                            end
                            else if (!pause_ack[i] || hold == `RXPFT_ACK_HOLD_LAST)
                                st <= ST_IDLE;
                            else
                                hold <= hold + 5'h01;
                        default:
                            st <= ST_IDLE;
                    endcase
                end
            end
        end
    endgenerate

endmodule // rxpft_top
`default_nettype wire

// ===== dv/rxpft_asserts.sv
// Port checker for the receive pause termination block.
// Assumes it is bound to rxpft_top: one clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
`include "rxpft_regs.vh"
module rxpft_asserts
(
    input wire logic        clock,     // Block clock
    input wire logic        rst,       // Synchronous reset
    input wire logic [7:0]  addr,      // Register address
    input wire logic        rd_en,     // Read strobe
    input wire logic [31:0] rd_data,   // Read data
    input wire logic        rx_valid,  // Byte valid
    input wire logic        rx_eof,    // Last byte
    input wire logic [8:0]  pause_req, // Requests
    input wire logic        ctrl_fwd,  // Forward pulse
    input wire logic        ctrl_drop  // Drop pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    fwd_drop_excl_a: assert property (!(ctrl_fwd && ctrl_drop))
        else $error("forward and drop together");
    fwd_after_eof_a: assert property (ctrl_fwd |-> $past(rx_valid && rx_eof, 2))
        else $error("forward without frame end");
    drop_after_eof_a: assert property (ctrl_drop |-> $past(rx_valid && rx_eof, 2))
        else $error("drop without frame end");
    req_rise_frame_a: assert property ((pause_req & ~$past(pause_req)) != 9'h000 |-> $past(rx_valid && rx_eof, 2))
        else $error("request rose without frame");
    req_rise_ctrl_a: assert property ((pause_req & ~$past(pause_req)) != 9'h000 |-> ctrl_fwd || ctrl_drop)
        else $error("request rose on non-control frame");
    class_excl_a: assert property (!($rose(pause_req[8]) && (pause_req[7:0] & ~$past(pause_req[7:0])) != 8'h00))
        else $error("global and priority raised together");
    status_read_a: assert property (rd_en && addr == `RXPFT_STATUS |=> rd_data == {23'h0, $past(pause_req)})
        else $error("status read differs from requests");
    rd_idle_zero_a: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data outside read cycle");
endmodule // rxpft_asserts

bind rxpft_top rxpft_asserts i_asserts (.clock(clock), .rst(rst), .addr(addr), .rd_en(rd_en),
    .rd_data(rd_data), .rx_valid(rx_valid), .rx_eof(rx_eof), .pause_req(pause_req),
    .ctrl_fwd(ctrl_fwd), .ctrl_drop(ctrl_drop));
`default_nettype wire

// ===== dv/rxpft_user_model.sv
// Behavioural user flow-control logic answering pause requests.
// Assumes the block's clock and reset; ack_delay sets the answer latency.
`timescale 1ns/1ns
`default_nettype none
module rxpft_user_model
(
    input  wire logic       clock,     // Block clock
    input  wire logic       rst,       // Synchronous reset
    input  wire logic [8:0] pause_req, // Requests, bit 8 global
    input  wire logic [7:0] ack_delay, // Answer latency
    output var  logic [8:0] pause_ack  // Acknowledges
);
    logic [7:0] wait_cnt [0:8];

    always @(posedge clock)
    begin
        for (int i = 0; i < 9; i++)
        begin
            if (rst)
            begin
                pause_ack[i] <= 1'b0;
                wait_cnt[i]  <= 8'h00;
            end
            else if (pause_req[i] && !pause_ack[i])
            begin
                wait_cnt[i] <= wait_cnt[i] + 8'h01;
                if (wait_cnt[i] >= ack_delay)
                    pause_ack[i] <= 1'b1;
            end
            else
            begin
                wait_cnt[i] <= 8'h00;
                if (!pause_req[i])
                    pause_ack[i] <= 1'b0;
            end
        end
    end
endmodule // rxpft_user_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the receive pause termination block.
// Assumes rxpft_top, the user model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
`include "rxpft_regs.vh"
module testbench;
    localparam logic [47:0] MC_DA = `RXPFT_FIXED_MDA;
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        rx_valid;
    logic        rx_sof;
    logic        rx_eof;
    logic [7:0]  rx_byte;
    logic [8:0]  pause_ack;
    logic [8:0]  pause_req;
    logic        ctrl_fwd;
    logic        ctrl_drop;
    logic [7:0]  ack_delay;
    int          err_count;
    int          n_tests;

    rxpft_top i_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_byte(rx_byte), .pause_ack(pause_ack), .pause_req(pause_req), .ctrl_fwd(ctrl_fwd),
        .ctrl_drop(ctrl_drop));
    rxpft_user_model i_user (.clock(clock), .rst(rst), .pause_req(pause_req),
        .ack_delay(ack_delay), .pause_ack(pause_ack));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    // Frame: DA, zero SA, ethertype 8808, opcode, 18 body bytes
    task automatic send_frame(input logic [47:0] da, input logic [15:0] op, input logic [143:0] body);
        logic [271:0] f;
        f = {da, 48'h0, 16'h8808, op, body};
        for (int i = 0; i < 34; i++)
        begin
            @(posedge clock);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == 33);
            rx_byte  <= f[271 - 8*i -: 8];
        end
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_eof   <= 1'b0;
    endtask

    // Called just after the end-byte edge; pulses stand only in the next cycle
    task automatic after_frame(input logic [8:0] req, input logic [1:0] fd);
        @(posedge clock);
        #1;
        chk(32'(pause_req), 32'(req));
        chk(32'({ctrl_fwd, ctrl_drop}), 32'(fd));
    endtask

    task automatic wait_req(input logic [8:0] exp, input int lim);
        int k;
        k = 0;
        while (pause_req !== exp && k < lim)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        chk(32'(pause_req), 32'(exp));
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        err_count++;
        end_of_test();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_byte = 8'h00;
        ack_delay = 8'hff;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd_chk(`RXPFT_CTRL, 32'h0);
        rd_chk(`RXPFT_CHECK, 32'h0);
        rd_chk(`RXPFT_MDA_LO, 32'hc200_0001);
        rd_chk(`RXPFT_MDA_HI, 32'h0000_0180);
        rd_chk(`RXPFT_ETYPE_PAUSE, 32'h8808_8808);
        rd_chk(`RXPFT_OPC_PCP, 32'hffff_0000);
        rd_chk(`RXPFT_OPC_PAUSE, 32'h0101_0001);
        rd_chk(8'h38, 32'h0);
        wr(`RXPFT_STATUS, 32'h0000_01ff);
        rd_chk(`RXPFT_STATUS, 32'h0);
        // Global pause, no ack checking; the late ack proves counting starts at once
        wr(`RXPFT_CTRL, 32'h01ff_0001);
        wr(`RXPFT_CHECK, 32'h393a_0022);
        send_frame(MC_DA, 16'h0001, {16'h0006, 128'h0});
        after_frame(9'h100, 2'b10);
        rd_chk(`RXPFT_STATUS, 32'h0000_0100);
        send_frame(MC_DA, 16'h0001, {16'h0006, 128'h0});
        after_frame(9'h100, 2'b10);
        repeat (22) @(posedge clock);
        #1;
        chk(32'(pause_req), 32'h0000_0100);
        wait_req(9'h000, 60);
        send_frame(48'h0180_c200_0002, 16'h0001, 144'h0);
        after_frame(9'h000, 2'b00);
        send_frame(MC_DA, 16'h0002, {16'h0001, 128'h0});
        after_frame(9'h000, 2'b10);
        // Priority pause by unicast; class 2 masked, classes 3 to 7 absent from vector
        wr(`RXPFT_UDA_LO, 32'h3344_5566);
        wr(`RXPFT_UDA_HI, 32'h0000_1122);
        wr(`RXPFT_CHECK, 32'h393a_2122);
        wr(`RXPFT_CTRL, 32'h01fb_0000);
        send_frame(48'h1122_3344_5566, 16'h0101, {8'h00, 8'h07, 16'h0001, 16'h0005, 16'h0003, 80'h0});
        after_frame(9'h003, 2'b01);
        wait_req(9'h002, 20);
        wait_req(9'h000, 60);
        // Opcode window 5..7 and programmable multicast for priority control
        wr(`RXPFT_OPC_GCP, 32'h0007_0005);
        wr(`RXPFT_MDA_LO, 32'hc200_0002);
        wr(`RXPFT_CHECK, 32'h393a_2232);
        send_frame(MC_DA, 16'h0007, 144'h0);
        after_frame(9'h000, 2'b01);
        send_frame(MC_DA, 16'h0008, 144'h0);
        after_frame(9'h000, 2'b00);
        send_frame(MC_DA, 16'h0004, 144'h0);
        after_frame(9'h000, 2'b00);
        send_frame(48'h0180_c200_0002, 16'h0008, 144'h0);
        after_frame(9'h000, 2'b01);
        // Ack checking; enables cleared while the handshake runs
        wr(`RXPFT_CHECK, 32'h393a_0022);
        wr(`RXPFT_CTRL, 32'h01ff_0003);
        ack_delay <= 8'h14;
        send_frame(MC_DA, 16'h0001, {16'h0001, 128'h0});
        after_frame(9'h100, 2'b10);
        wr(`RXPFT_CTRL, 32'h0000_0003);
        repeat (12) @(posedge clock);
        #1;
        chk(32'(pause_req), 32'h0000_0100);
        wait_req(9'h000, 40);
        send_frame(MC_DA, 16'h0001, {16'h0001, 128'h0});
        after_frame(9'h000, 2'b10);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
